// [asr_host.sv]
/*
  Host controller that runs single read and write cycles on an asynchronous
  static memory. Assumes the memory pins sit on a wire the testbench resolves
  from byte_data_lines_oe_o, and that requests come from logic on clk_i.
*/
`timescale 1ns/1ps
module asr_host (
  input  wire logic                        clk_i,
  input  wire logic                        reset_i,
  input  wire logic                        req_valid_i,
  output logic                             req_ready_o,
  input  wire asr_pkg::asr_req_t           req_i,
  output logic                             rsp_valid_o,
  output logic [asr_pkg::DATA_W-1:0]       rsp_data_o,
  output asr_pkg::asr_pins_t               pins_o,
  input  wire logic [asr_pkg::DATA_W-1:0]  byte_data_lines_i,
  output logic [asr_pkg::DATA_W-1:0]       byte_data_lines_o,
  output logic                             byte_data_lines_oe_o
);
  import asr_pkg::*;

  // ****************************************************************
  // Pin input synchroniser.
  // ****************************************************************
  // The memory answers without a clock, so its bus is treated as an
  // asynchronous pin and sampled through two stages; the read counter
  // pays for them with extra cycles.
  logic [DATA_W-1:0] data_meta;
  logic [DATA_W-1:0] data_sync;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      data_meta <= '0;
      data_sync <= '0;
    end else begin
      data_meta <= byte_data_lines_i;
      data_sync <= data_meta;
    end
  end

  // ****************************************************************
  // Cycle sequencer.
  // ****************************************************************
  asr_state_t state;
  logic [3:0] cnt;
  logic       is_write;

  assign req_ready_o = (state == ASR_IDLE);

  // Address and write flag are held for the whole cycle so address hold
  // after write end is at least two full clocks, well above zero.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state    <= ASR_IDLE;
      cnt      <= CNT_ZERO;
      is_write <= 1'b0;
    end else begin
      unique case (state)
        ASR_IDLE: begin
          // A request that arrives while busy is simply not taken; ready
          // tells the requester when to try again.
          if (req_valid_i) begin
            is_write <= req_i.write;
            state    <= ASR_SETUP;
          end
        end
        ASR_SETUP: begin
          // Read waits the access time plus two synchroniser stages.
          cnt   <= is_write ? 4'(WRITE_CYC) : 4'(READ_CYC + SYNC_STAGES);
          state <= ASR_ACTIVE;
        end
        ASR_ACTIVE: begin
          if (cnt == CNT_ONE) begin
            state <= ASR_FINISH;
          end
          cnt <= cnt - CNT_ONE;
        end
        ASR_FINISH: begin
          state <= ASR_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Pin drivers.
  // ****************************************************************
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pins_o.sel_n              <= 1'b1;
      pins_o.out_en_n           <= 1'b1;
      pins_o.wr_n               <= 1'b1;
      pins_o.word_address_lines <= '0;
      byte_data_lines_o         <= '0;
      byte_data_lines_oe_o      <= 1'b0;
    end else begin
      unique case (state)
        ASR_IDLE: begin
          if (req_valid_i) begin
            // Address and data go out a full cycle before any strobe falls.
            pins_o.word_address_lines <= req_i.addr;
            byte_data_lines_o         <= req_i.wdata;
            byte_data_lines_oe_o      <= req_i.write;
          end
        end
        ASR_SETUP: begin
          pins_o.sel_n    <= 1'b0;
          pins_o.wr_n     <= ~is_write;
          pins_o.out_en_n <= is_write;
        end
        ASR_ACTIVE: begin
          if (cnt == CNT_ONE) begin
            // Strobe and select rise together; data stays one cycle after.
            pins_o.sel_n    <= 1'b1;
            pins_o.wr_n     <= 1'b1;
            pins_o.out_en_n <= 1'b1;
          end
        end
        ASR_FINISH: begin
          // Letting go one cycle after the strobe rose covers data hold.
          byte_data_lines_oe_o <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Read data capture.
  // ****************************************************************
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o  <= '0;
    end else begin
      rsp_valid_o <= 1'b0;
      if (state == ASR_ACTIVE && cnt == CNT_ONE && !is_write) begin
        rsp_valid_o <= 1'b1;
        rsp_data_o  <= data_sync;
      end
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  // Pin protocol and request side checks. The repetition counts follow
  // the package timing at 10 MHz and must be revisited if it changes.
  // A wedged sequencer would hold ready low forever; counting busy cycles
  // turns that hang into a bounded check rather than a silent stall.
  localparam logic [3:0] BUSY_MAX = 4'(READ_CYC + SYNC_STAGES + OVERHEAD_CYC);
  logic       [3:0] busy_cnt;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_cnt <= CNT_ZERO;
    end else if (req_ready_o) begin
      busy_cnt <= CNT_ZERO;
    end else begin
      busy_cnt <= busy_cnt + CNT_ONE;
    end
  end

  AST_NO_DRIVE_ON_READ: assert property (@(posedge clk_i) disable iff (reset_i)
    !pins_o.out_en_n |-> !byte_data_lines_oe_o)
    else $error("Host drives data while memory output enabled.");
  AST_WR_HIGH_READ: assert property (@(posedge clk_i) disable iff (reset_i)
    !pins_o.out_en_n |-> pins_o.wr_n)
    else $error("Write strobe low during read.");
  AST_WR_NEEDS_SEL: assert property (@(posedge clk_i) disable iff (reset_i)
    !pins_o.wr_n |-> !pins_o.sel_n && byte_data_lines_oe_o)
    else $error("Write strobe low without select or data.");
  AST_ADDR_BEFORE_SEL: assert property (@(posedge clk_i) disable iff (reset_i)
    $fell(pins_o.sel_n) |-> $stable(pins_o.word_address_lines))
    else $error("Address changed as select fell.");
  AST_ADDR_STABLE: assert property (@(posedge clk_i) disable iff (reset_i)
    !pins_o.sel_n |=> $stable(pins_o.word_address_lines))
    else $error("Address moved during a cycle.");
  AST_DATA_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(pins_o.wr_n) |-> byte_data_lines_oe_o && $stable(byte_data_lines_o))
    else $error("Write data not held at write end.");
  AST_WRITE_LEN: assert property (@(posedge clk_i) disable iff (reset_i)
    $fell(pins_o.wr_n) |-> !pins_o.wr_n [*1] ##1 pins_o.wr_n)
    else $error("Write pulse length wrong.");
  AST_READ_RSP: assert property (@(posedge clk_i) disable iff (reset_i)
    $fell(pins_o.out_en_n) |-> ##[1:6] rsp_valid_o)
    else $error("Read answer missing.");
  AST_OE_HIGH_WRITE: assert property (@(posedge clk_i) disable iff (reset_i)
    byte_data_lines_oe_o |-> pins_o.out_en_n)
    else $error("Output enable low while host drives.");
  AST_IDLE_PINS: assert property (@(posedge clk_i) disable iff (reset_i)
    req_ready_o |-> pins_o.sel_n && pins_o.wr_n && pins_o.out_en_n)
    else $error("Memory still selected while idle.");
  AST_IDLE_RELEASED: assert property (@(posedge clk_i) disable iff (reset_i)
    req_ready_o |-> !byte_data_lines_oe_o)
    else $error("Host drives data while idle.");
  AST_SEL_WITH_STROBE: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(pins_o.sel_n) |-> pins_o.wr_n)
    else $error("Select released before write strobe.");
  AST_DATA_SETUP: assert property (@(posedge clk_i) disable iff (reset_i)
    $fell(pins_o.wr_n) |-> byte_data_lines_oe_o && $stable(byte_data_lines_o))
    else $error("Write data not set up before strobe fell.");
  AST_WR_OE_HIGH: assert property (@(posedge clk_i) disable iff (reset_i)
    !pins_o.wr_n |-> pins_o.out_en_n)
    else $error("Output enable low during write.");
  AST_READ_LEN: assert property (@(posedge clk_i) disable iff (reset_i)
    $fell(pins_o.out_en_n) |-> !pins_o.out_en_n [*3] ##1 pins_o.out_en_n)
    else $error("Read window length wrong.");
  AST_RSP_FROM_READ: assert property (@(posedge clk_i) disable iff (reset_i)
    rsp_valid_o |-> !$past(pins_o.out_en_n))
    else $error("Read answer without a read window.");
  AST_RSP_PULSE: assert property (@(posedge clk_i) disable iff (reset_i)
    rsp_valid_o |=> !rsp_valid_o)
    else $error("Read answer longer than one cycle.");
  AST_RSP_DATA_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
    !rsp_valid_o |-> $stable(rsp_data_o))
    else $error("Read data changed without an answer.");
  AST_TAKE_BUSY: assert property (@(posedge clk_i) disable iff (reset_i)
    req_valid_i && req_ready_o |=> !req_ready_o)
    else $error("Request taken but host still idle.");
  AST_BUSY_BOUND: assert property (@(posedge clk_i) disable iff (reset_i)
    busy_cnt <= BUSY_MAX)
    else $error("Access took longer than its cycle budget.");
endmodule // asr_host

// [asr_pkg.sv]
/*
  Constants, states and carrier types for the host-side controller of an
  asynchronous 32K x 8 static memory. Assumes a single 10 MHz system clock.
*/
package asr_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  // ****************************************************************
  // Timing, slowest grade, in ns, and derived cycle counts at 10 MHz.
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int READ_ACCESS_NS = 70;
  localparam int WRITE_PULSE_NS = 60;
  localparam int DATA_SETUP_NS = 30;
  localparam int READ_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYC_A = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYC_B = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYC = (WRITE_CYC_A > WRITE_CYC_B) ? WRITE_CYC_A : WRITE_CYC_B;
  // Two flops on the data bus, plus one setup and one finish cycle per access.
  localparam int SYNC_STAGES = 2;
  localparam int OVERHEAD_CYC = 2;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;

  typedef enum logic [3:0] {
    ASR_IDLE   = 4'b0001,
    ASR_SETUP  = 4'b0010,
    ASR_ACTIVE = 4'b0100,
    ASR_FINISH = 4'b1000
  } asr_state_t;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asr_req_t;

  typedef struct packed {
    logic              sel_n;
    logic              out_en_n;
    logic              wr_n;
    logic [ADDR_W-1:0] word_address_lines;
  } asr_pins_t;
endpackage

// [asr_mem_model.sv]
/*
  Behavioural 32K x 8 static memory answering the host's pins.
  Assumes the bench resolves the shared data bus from both enables.
*/
`timescale 1ns/1ps
module asr_mem_model #(
  parameter int ACCESS_NS = 70
) (
  input  wire asr_pkg::asr_pins_t          pins_i,
  input  wire logic [asr_pkg::DATA_W-1:0]  bus_i,
  output logic [asr_pkg::DATA_W-1:0]       dout_o,
  output logic                             doe_o
);
  import asr_pkg::*;
  logic [DATA_W-1:0] mem [0:32767];
  logic              wr_act = 1'b0;
  // Output enable high or strobe low keeps the pins released for the host.
  assign doe_o = !pins_i.sel_n && pins_i.wr_n && !pins_i.out_en_n;
  // The slow grade delay makes an early sample by the host visible.
  assign #(ACCESS_NS) dout_o = mem[pins_i.word_address_lines];
  always @(pins_i.sel_n or pins_i.wr_n) begin
    if (wr_act && (pins_i.sel_n || pins_i.wr_n)) begin
      mem[pins_i.word_address_lines] = bus_i;
    end
    wr_act = !pins_i.sel_n && !pins_i.wr_n;
  end
endmodule // asr_mem_model

// [test_async_sram_32k_by_8_port.sv]
/*
  Self-checking bench for the static memory host controller.
  Assumes asr_pkg, asr_host and asr_mem_model are compiled first.
*/
`timescale 1ns/1ps
module test_async_sram_32k_by_8_port;
  import asr_pkg::*;
  logic              clk_i = 0, reset_i = 1, req_valid_i = 0;
  asr_req_t          req_i = '0;
  logic              req_ready_o, rsp_valid_o, byte_data_lines_oe_o, moe;
  logic [DATA_W-1:0] rsp_data_o, byte_data_lines_o, md, bus, flt = 8'h0F;
  asr_pins_t         pins_o;
  // Select, strobe, output enable and host drive, looked at together.
  wire [3:0]         ctl = {pins_o.sel_n, pins_o.wr_n, pins_o.out_en_n, byte_data_lines_oe_o};
  int                err_count = 0, check_count = 0, cyc = 0;
  always #50 clk_i = ~clk_i;
  // A released bus shows a toggling pattern, never the last driven byte.
  always @(posedge clk_i) flt <= ~flt;
  assign bus = byte_data_lines_oe_o ? byte_data_lines_o : (moe ? md : flt);
  asr_host dut (.clk_i(clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_i(req_i), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .pins_o(pins_o), .byte_data_lines_i(bus),
    .byte_data_lines_o(byte_data_lines_o), .byte_data_lines_oe_o(byte_data_lines_oe_o));
  asr_mem_model mem (.pins_i(pins_o), .bus_i(bus), .dout_o(md), .doe_o(moe));
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic take(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    while (req_ready_o !== 1'b1) begin
      @(posedge clk_i);
      #1;
    end
    req_i.write = w;
    req_i.addr = a;
    req_i.wdata = d;
    req_valid_i = 1;
    @(posedge clk_i);
    #1 req_valid_i = 0;
  endtask
  task automatic do_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    take(1, a, d);
    @(posedge clk_i); #1;
    chk("wr open", {4'b0011, a}, {ctl, pins_o.word_address_lines});
    @(posedge clk_i); #1;
    chk("wr close", {4'b1111, 4'h0, d}, {ctl, 4'h0, bus});
    @(posedge clk_i); #1;
    chk("wr release", 24'hE, {20'h0, ctl});
    @(posedge clk_i); #1;
    chk("wr ready", 24'h1, {23'h0, req_ready_o});
  endtask
  task automatic do_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    int rsp_at = 1 + READ_CYC + SYNC_STAGES;
    take(0, a, 8'h00);
    for (int i = 1; i <= 7; i++) begin
      @(posedge clk_i); #1;
      chk("rd strobe", 24'h2, {22'h0, pins_o.wr_n, byte_data_lines_oe_o});
      chk("rd valid", {23'h0, i == rsp_at}, {23'h0, rsp_valid_o});
      if (i == 1) begin
        chk("rd open", {4'b0100, a}, {ctl, pins_o.word_address_lines});
      end
      if (i == rsp_at) begin
        chk("rd close", 24'hE, {20'h0, ctl});
      end
    end
    chk("rd data", {16'h0, e}, {16'h0, rsp_data_o});
  endtask
  task automatic s_corners;
    logic [ADDR_W-1:0] ad [3] = '{15'h0000, 15'h7FFF, 15'h5555};
    logic [DATA_W-1:0] dv [3] = '{8'hA5, 8'h5A, 8'h3C};
    for (int i = 0; i < 3; i++) do_write(ad[i], dv[i]);
    for (int i = 2; i >= 0; i--) do_read(ad[i], dv[i]);
  endtask
  task automatic s_overwrite;
    do_write(15'h2AAA, 8'hFF);
    do_write(15'h2AAA, 8'h00);
    do_read(15'h2AAA, 8'h00);
    do_read(15'h7FFF, 8'h5A);
  endtask
  task automatic s_reset_mid;
    take(0, 15'h7FFF, 8'h00);
    @(posedge clk_i); #1;
    reset_i = 1;
    #1;
    chk("rst pins", 24'hE, {20'h0, ctl});
    chk("rst ready", 24'h1, {23'h0, req_ready_o});
    @(posedge clk_i); #1;
    reset_i = 0;
    repeat (6) begin
      @(posedge clk_i); #1;
      chk("rst quiet", 24'hE, {19'h0, rsp_valid_o, ctl});
    end
    do_read(15'h7FFF, 8'h5A);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    #1 reset_i = 0;
    chk("idle pins", 24'h7, {pins_o.sel_n, pins_o.out_en_n, pins_o.wr_n});
    s_corners();
    s_overwrite();
    s_reset_mid();
    end_of_test();
  end
endmodule // test_async_sram_32k_by_8_port
